// ---- rtl/disk_cmd_defines.svh ----
`ifndef DISK_CMD_DEFINES_SVH
`define DISK_CMD_DEFINES_SVH

// Host register address, A2..A1 (A0 selects the byte in 8-bit mode)
`define CMD_STAT_ADDR 2'h3

// Status word bit positions
`define ST_HEADER_MISSING 0
`define ST_HEADER_CHECK 1
`define ST_PAYLOAD_MISSING 2
`define ST_PAYLOAD_CHECK 3
`define ST_UNUSED 4
`define ST_XFER_REQ 5
`define ST_FAULT 6
`define ST_BUF_SEL_LO 7
`define ST_SEEK_FAIL 8
`define ST_SETTLED 9
`define ST_READY 10
`define ST_WLOCK 11
`define ST_SELECTED 12
`define ST_BUSY 13
`define ST_ACTIVE 14
`define ST_BUF_SEL_HI 15

// Command word field positions
`define CW_OP_HI 15
`define CW_OP_LO 12
`define CW_CRC_VERIFY 11
`define CW_SECTOR_MODE 10
`define CW_SETTLE_REQ 9
`define CW_INT_EN 8
`define CW_VOL_HEAD 7
`define CW_CYL 6
`define CW_HEAD 5
`define CW_MARGINAL 4
`define CW_UNIT_HI 3
`define CW_UNIT_LO 0

// Opcodes
`define OP_FAULT_CLEAR 4'h8
`define OP_RETURN_ZERO 4'h9
`define OP_SEEK 4'hA
`define OP_READ_ID 4'hB
`define OP_READ_SECTOR 4'hC
`define OP_WRITE_SECTOR 4'hD
`define OP_FORMAT 4'hE
`define OP_VERIFY 4'hF

// Reset values
`define ERR_RESET 4'h0
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define UNIT_RESET 4'h0

`endif

// ---- rtl/disk_cmd_pkg.sv ----
package disk_cmd_pkg;
`include "disk_cmd_defines.svh"

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_FAULT_CLEAR = `OP_FAULT_CLEAR,
    OP_RETURN_ZERO = `OP_RETURN_ZERO,
    OP_SEEK = `OP_SEEK,
    OP_READ_ID = `OP_READ_ID,
    OP_READ_SECTOR = `OP_READ_SECTOR,
    OP_WRITE_SECTOR = `OP_WRITE_SECTOR,
    OP_FORMAT = `OP_FORMAT,
    OP_VERIFY = `OP_VERIFY
  } cmd_op_t;

  typedef enum logic {
    PHASE_IDLE,
    PHASE_HIGH_HELD
  } byte_phase_t;

endpackage

// ---- rtl/command_field_decoder.sv ----
`timescale 1ns/1ps
`include "disk_cmd_defines.svh"

module command_field_decoder
(
  input wire logic [15:0] word_in,
  output logic legal_out,
  output disk_cmd_pkg::cmd_op_t op_out,
  output logic crc_verify_out,
  output logic sector_mode_out,
  output logic settle_req_out,
  output logic int_en_out,
  output logic vol_head_out,
  output logic cyl_out,
  output logic head_out,
  output logic marginal_out,
  output logic [3:0] unit_flags_out
);

  wire [3:0] code = word_in[`CW_OP_HI:`CW_OP_LO];
  wire is_fault = (code == `OP_FAULT_CLEAR);
  wire is_rtz = (code == `OP_RETURN_ZERO);
  wire is_write = (code == `OP_WRITE_SECTOR);
  wire is_format = (code == `OP_FORMAT);
  // Only opcodes with the top bit set exist
  wire legal = word_in[`CW_OP_HI];
  wire positioned = legal & ~is_fault & ~is_rtz;

  assign legal_out = legal;
  assign op_out = legal ? disk_cmd_pkg::cmd_op_t'(code) : disk_cmd_pkg::OP_NONE;
  // One bit, meaning set by opcode: verify for seek, CRC enable otherwise
  assign crc_verify_out = positioned & word_in[`CW_CRC_VERIFY];
  assign sector_mode_out = positioned & word_in[`CW_SECTOR_MODE];
  assign settle_req_out = legal & word_in[`CW_SETTLE_REQ];
  assign int_en_out = legal & word_in[`CW_INT_EN];
  assign vol_head_out = positioned & word_in[`CW_VOL_HEAD];
  assign cyl_out = positioned & word_in[`CW_CYL];
  assign head_out = positioned & word_in[`CW_HEAD];
  assign marginal_out = legal & ~is_fault & ~is_write & ~is_format
    & word_in[`CW_MARGINAL];
  assign unit_flags_out = word_in[`CW_UNIT_HI:`CW_UNIT_LO];

endmodule

// ---- rtl/disk_command_status_unit.sv ----
`timescale 1ns/1ps
`include "disk_cmd_defines.svh"


module disk_command_status_unit
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Host side
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic [2:0] addr_in,
  input wire logic byte_mode_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  // Sequencer side
  input wire logic command_done_in,
  input wire logic header_missing_in,
  input wire logic header_check_error_in,
  input wire logic payload_missing_in,
  input wire logic payload_check_error_in,
  input wire logic buffer_select_out_in,
  input wire logic buffer_transfer_request_in,
  // Drive status inputs
  input wire logic drive_fault_in,
  input wire logic seek_failure_in,
  input wire logic track_settled_in,
  input wire logic drive_ready_in,
  input wire logic write_locked_in,
  input wire logic drive_selected_in,
  input wire logic drive_busy_in,
  // Decoded command
  output logic command_start_out,
  output logic command_active_out,
  output disk_cmd_pkg::cmd_op_t op_out,
  output logic crc_verify_out,
  output logic sector_mode_out,
  output logic settle_req_out,
  output logic int_en_out,
  output logic vol_head_out,
  output logic cyl_out,
  output logic head_out,
  output logic marginal_out,
  output logic [3:0] unit_flags_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode

  logic wr_prev_reg;
  logic rd_prev_reg;
  logic command_active_reg;
  logic [7:0] high_byte_reg;
  disk_cmd_pkg::byte_phase_t phase_reg;
  disk_cmd_pkg::byte_phase_t phase_next;

  wire addr_hit = ~cs_n_in & (addr_in[2:1] == `CMD_STAT_ADDR);
  wire wr_level = addr_hit & ~we_n_in;
  wire rd_level = addr_hit & ~re_n_in;
  // Act once per strobe, on its leading edge
  wire wr_edge = wr_level & ~wr_prev_reg;
  wire rd_edge = rd_level & ~rd_prev_reg;
  // A0 only picks a byte lane in byte mode
  wire upper_sel = addr_in[0];

  wire byte_high_wr = wr_edge & byte_mode_in & upper_sel;
  wire byte_low_wr = wr_edge & byte_mode_in & ~upper_sel;
  wire full_wr = wr_edge & ~byte_mode_in;

  // Lower byte alone is dropped: no partial command ever starts
  wire word_done = full_wr
    | (byte_low_wr & (phase_reg == disk_cmd_pkg::PHASE_HIGH_HELD));
  wire [15:0] staged_word = byte_mode_in ? {high_byte_reg, data_in[15:8]} : data_in;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and accept

  logic legal;
  disk_cmd_pkg::cmd_op_t dec_op;
  logic dec_crc_verify;
  logic dec_sector_mode;
  logic dec_settle_req;
  logic dec_int_en;
  logic dec_vol_head;
  logic dec_cyl;
  logic dec_head;
  logic dec_marginal;
  logic [3:0] dec_unit_flags;

  // Fields are masked per opcode before they reach the latches
  command_field_decoder decoder
  (
    .word_in(staged_word),
    .legal_out(legal),
    .op_out(dec_op),
    .crc_verify_out(dec_crc_verify),
    .sector_mode_out(dec_sector_mode),
    .settle_req_out(dec_settle_req),
    .int_en_out(dec_int_en),
    .vol_head_out(dec_vol_head),
    .cyl_out(dec_cyl),
    .head_out(dec_head),
    .marginal_out(dec_marginal),
    .unit_flags_out(dec_unit_flags)
  );

  // Writes during execution leave the running command untouched
  wire accept = word_done & legal & ~command_active_reg;

  // Busy drops a held upper byte, so no stale half pairs up later
  always_comb
  begin
    phase_next = phase_reg;
    if (command_active_reg)
    begin
      phase_next = disk_cmd_pkg::PHASE_IDLE;
    end
    else if (byte_high_wr)
    begin
      phase_next = disk_cmd_pkg::PHASE_HIGH_HELD;
    end
    else if (byte_low_wr | full_wr)
    begin
      phase_next = disk_cmd_pkg::PHASE_IDLE;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      phase_reg <= disk_cmd_pkg::PHASE_IDLE;
      high_byte_reg <= `BYTE_RESET;
    end
    else
    begin
      wr_prev_reg <= wr_level;
      rd_prev_reg <= rd_level;
      phase_reg <= phase_next;
      if (byte_high_wr & ~command_active_reg)
      begin
        high_byte_reg <= data_in[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command active and latched fields

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      command_active_reg <= 1'b0;
      command_start_out <= 1'b0;
    end
    else
    begin
      command_start_out <= accept;
      if (accept)
      begin
        command_active_reg <= 1'b1;
      end
      else if (command_done_in)
      begin
        command_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      op_out <= disk_cmd_pkg::OP_NONE;
      crc_verify_out <= 1'b0;
      sector_mode_out <= 1'b0;
      settle_req_out <= 1'b0;
      int_en_out <= 1'b0;
      vol_head_out <= 1'b0;
      cyl_out <= 1'b0;
      head_out <= 1'b0;
      marginal_out <= 1'b0;
      unit_flags_out <= `UNIT_RESET;
    end
    else if (accept)
    begin
      op_out <= dec_op;
      crc_verify_out <= dec_crc_verify;
      sector_mode_out <= dec_sector_mode;
      settle_req_out <= dec_settle_req;
      int_en_out <= dec_int_en;
      vol_head_out <= dec_vol_head;
      cyl_out <= dec_cyl;
      head_out <= dec_head;
      marginal_out <= dec_marginal;
      unit_flags_out <= dec_unit_flags;
    end
  end

  assign command_active_out = command_active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky error flags, cleared by the next accepted command

  logic [3:0] err_reg;

  // A new command starts with clean error flags
  wire err_clear = accept;
  wire [3:0] err_event = {payload_check_error_in, payload_missing_in,
    header_check_error_in, header_missing_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_err
      always_ff @(posedge core_clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          err_reg[gi] <= 1'b0;
        end
        else if (err_event[gi])
        begin
          // Set wins over the clear of a new command
          err_reg[gi] <= 1'b1;
        end
        else if (err_clear)
        begin
          err_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status word and read path

  // One inverter feeds both copies so they can never differ
  wire buffer_select_shown = ~buffer_select_out_in;
  wire [15:0] status_word;
  assign status_word[`ST_PAYLOAD_CHECK:`ST_HEADER_MISSING] = err_reg;
  assign status_word[`ST_UNUSED] = 1'b0;
  assign status_word[`ST_XFER_REQ] = buffer_transfer_request_in;
  assign status_word[`ST_FAULT] = drive_fault_in;
  assign status_word[`ST_BUF_SEL_LO] = buffer_select_shown;
  assign status_word[`ST_SEEK_FAIL] = seek_failure_in;
  assign status_word[`ST_SETTLED] = track_settled_in;
  assign status_word[`ST_READY] = drive_ready_in;
  assign status_word[`ST_WLOCK] = write_locked_in;
  assign status_word[`ST_SELECTED] = drive_selected_in;
  assign status_word[`ST_BUSY] = drive_busy_in;
  assign status_word[`ST_ACTIVE] = command_active_reg;
  assign status_word[`ST_BUF_SEL_HI] = buffer_select_shown;

  // 8-bit reads land on the upper lanes, byte picked by A0
  wire [7:0] status_upper = status_word[15:8];
  wire [7:0] status_lower = status_word[7:0];
  wire [7:0] status_byte = upper_sel ? status_upper : status_lower;
  wire [15:0] read_word = byte_mode_in ? {status_byte, `BYTE_RESET} : status_word;

  // Snapshot taken at strobe start so the word is stable while read
  // Live bits freeze per strobe; a change mid-read shows on the next read
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      data_out <= `WORD_RESET;
    end
    else if (rd_edge)
    begin
      data_out <= read_word;
    end
  end

  // Drive only once the snapshot is in place
  assign data_oe_out = rd_level & rd_prev_reg;

endmodule

// ---- tb/disk_cmd_checker.sv ----
`timescale 1ns/1ps
module disk_cmd_checker
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic re_n_in,
  input wire logic [2:0] addr_in,
  input wire logic byte_mode_in,
  input wire logic command_done_in,
  input wire logic buffer_select_out_in,
  input wire logic buffer_transfer_request_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_out,
  input wire logic command_start_out,
  input wire logic command_active_out,
  input wire disk_cmd_pkg::cmd_op_t op_out,
  input wire logic crc_verify_out,
  input wire logic sector_mode_out,
  input wire logic vol_head_out,
  input wire logic cyl_out,
  input wire logic head_out,
  input wire logic marginal_out,
  input wire logic [3:0] unit_flags_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Leading edge of a word read only; byte reads land on other lanes
  logic rd_q;
  wire rd_hit = !cs_n_in && (addr_in[2:1] == 2'b11) && !re_n_in;
  wire rd_take = rd_hit && !rd_q && !byte_mode_in;
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rd_q <= 1'b0;
    else
      rd_q <= rd_hit;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_start_idle; command_start_out |-> !$past(command_active_out); endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  property p_start_pulse; command_start_out |=> !command_start_out; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_active_rise; $rose(command_active_out) |-> command_start_out; endproperty
  a_active_rise: assert property (p_active_rise) else $error("active w/o start");
  property p_active_done; command_active_out && command_done_in |=> !command_active_out;
  endproperty
  a_active_done: assert property (p_active_done) else $error("active stuck");
  property p_fields_hold; !command_start_out |-> $stable({op_out, unit_flags_out, marginal_out});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("fields moved");
  property p_op_legal; command_start_out |-> op_out[3]; endproperty
  a_op_legal: assert property (p_op_legal) else $error("bad opcode");
  property p_clear_flags; command_start_out && !op_out[2] && !op_out[1]
    |-> !(vol_head_out || cyl_out || head_out || crc_verify_out || sector_mode_out); endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flags not zero");
  property p_marg_zero; command_start_out && (op_out inside {disk_cmd_pkg::OP_FAULT_CLEAR,
    disk_cmd_pkg::OP_WRITE_SECTOR, disk_cmd_pkg::OP_FORMAT}) |-> !marginal_out; endproperty
  a_marg_zero: assert property (p_marg_zero) else $error("marginal set");
  property p_unused; data_oe_out |-> !data_out[4]; endproperty
  a_unused: assert property (p_unused) else $error("bit 4 set");
  property p_buf_sel; rd_take |=> (data_out[15] == data_out[7])
    && (data_out[7] == !$past(buffer_select_out_in)); endproperty
  a_buf_sel: assert property (p_buf_sel) else $error("buffer select bits");
  property p_live; rd_take |=> (data_out[5] == $past(buffer_transfer_request_in))
    && (data_out[14] == $past(command_active_out)); endproperty
  a_live: assert property (p_live) else $error("live bits");
endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model
(
  input wire logic clk_in,
  output logic cs_n_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic [2:0] addr_out,
  output logic byte_mode_out,
  output logic [15:0] data_out
);
  initial
  begin
    cs_n_out = 1'b1;
    we_n_out = 1'b1;
    re_n_out = 1'b1;
    addr_out = 3'h0;
    byte_mode_out = 1'b0;
    data_out = 16'h0000;
  end
  // Idle cycle after each access so the next strobe has a fresh leading edge
  task automatic put(input logic bm, input logic a0, input logic [15:0] d);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    we_n_out <= 1'b0;
    addr_out <= {2'b11, a0};
    byte_mode_out <= bm;
    data_out <= d;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    we_n_out <= 1'b1;
    data_out <= ~d; // Released bus has no pull
    @(posedge clk_in);
  endtask
  task automatic get(input logic bm, input logic a0);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    re_n_out <= 1'b0;
    addr_out <= {2'b11, a0};
    byte_mode_out <= bm;
    repeat (2) @(posedge clk_in);
    cs_n_out <= 1'b1;
    re_n_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in, reset_n_in, cs_n, we_n, re_n, bm, oe, start, active, done, oe_q;
  logic crc, sec, setl, ien, vh, cyl, hd, mg;
  logic [2:0] addr;
  logic [3:0] ev, err, uf;
  logic [8:0] lv;
  logic [15:0] din, dout, w, got, exp_w;
  logic [31:0] rng;
  disk_cmd_pkg::cmd_op_t op;
  logic [15:0] cmd_q[$], rd_q[$];
  int fails = 0;
  int compares = 0;
  host_model hm (.clk_in(core_clk_in), .cs_n_out(cs_n), .we_n_out(we_n), .re_n_out(re_n),
    .addr_out(addr), .byte_mode_out(bm), .data_out(din));
  disk_command_status_unit dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n), .we_n_in(we_n), .re_n_in(re_n), .addr_in(addr), .byte_mode_in(bm),
    .data_in(din), .data_out(dout), .data_oe_out(oe), .command_done_in(done),
    .header_missing_in(ev[0]), .header_check_error_in(ev[1]), .payload_missing_in(ev[2]),
    .payload_check_error_in(ev[3]), .buffer_select_out_in(lv[0]),
    .buffer_transfer_request_in(lv[1]), .drive_fault_in(lv[2]), .seek_failure_in(lv[3]),
    .track_settled_in(lv[4]), .drive_ready_in(lv[5]), .write_locked_in(lv[6]),
    .drive_selected_in(lv[7]), .drive_busy_in(lv[8]), .command_start_out(start),
    .command_active_out(active), .op_out(op), .crc_verify_out(crc), .sector_mode_out(sec),
    .settle_req_out(setl), .int_en_out(ien), .vol_head_out(vh), .cyl_out(cyl),
    .head_out(hd), .marginal_out(mg), .unit_flags_out(uf));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] stat(input logic act);
    return {~lv[0], act, lv[8:3], ~lv[0], lv[2:1], 1'b0, err};
  endfunction
  function automatic logic [15:0] mask(input logic [15:0] c);
    logic [15:0] m;
    m = c;
    if (c[15:12] inside {disk_cmd_pkg::OP_FAULT_CLEAR, disk_cmd_pkg::OP_RETURN_ZERO})
      m = m & 16'hf31f;
    if (c[15:12] inside {disk_cmd_pkg::OP_FAULT_CLEAR, disk_cmd_pkg::OP_WRITE_SECTOR,
      disk_cmd_pkg::OP_FORMAT})
      m[4] = 1'b0;
    return m;
  endfunction
  task automatic cmp_cmd(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t fields %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_stat(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t status %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic act, input logic bm, input logic a0);
    logic [15:0] s;
    s = stat(act);
    rd_q.push_back(bm ? {a0 ? s[15:8] : s[7:0], 8'h00} : s);
    hm.get(bm, a0);
  endtask
  task automatic close_out();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // Unexpected results compare against their own inverse so they always count
  initial
  begin
    oe_q = 1'b0;
    forever
    begin
      @(negedge core_clk_in);
      if (start === 1'b1)
      begin
        got = {op, crc, sec, setl, ien, vh, cyl, hd, mg, uf};
        exp_w = cmd_q.size() ? cmd_q.pop_front() : ~got;
        cmp_cmd(got, exp_w);
      end
      if (oe === 1'b1 && oe_q !== 1'b1)
      begin
        exp_w = rd_q.size() ? rd_q.pop_front() : ~dout;
        cmp_stat(dout, exp_w);
      end
      oe_q = oe;
    end
  end
  initial
  begin
    #100000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
  initial
  begin
    reset_n_in = 1'b0;
    done = 1'b0;
    ev = 4'h0;
    lv = 9'h000;
    err = 4'h0;
    rng = 32'hef12_736f;
    repeat (6) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    rd(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      lv <= rng[8:0];
      w = {1'b1, 3'(i), rng[27:16]};
      err = 4'h0;
      cmd_q.push_back(mask(w));
      if (i % 2 == 1)
      begin
        hm.put(1'b1, 1'b1, {w[15:8], 8'h00});
        hm.put(1'b1, 1'b0, {w[7:0], 8'h00});
      end
      else
        hm.put(1'b0, 1'b0, w);
      rd(1'b1, 1'b0, 1'b0);
      hm.put(1'b0, 1'b0, w ^ 16'h0fff);
      ev <= 4'h1 << (i % 4);
      @(posedge core_clk_in);
      ev <= 4'h0;
      err = 4'h1 << (i % 4);
      rd(1'b1, 1'b0, 1'b0);
      rd(1'b1, 1'b1, i[0]);
      done <= 1'b1;
      @(posedge core_clk_in);
      done <= 1'b0;
      rd(1'b0, 1'b0, 1'b0);
    end
    // Refused: top bit clear, orphan low byte, upper byte lost while busy
    hm.put(1'b0, 1'b0, 16'h7fff);
    hm.put(1'b1, 1'b0, 16'hc500);
    cmd_q.push_back(mask(16'hd0ff));
    err = 4'h0;
    hm.put(1'b0, 1'b0, 16'hd0ff);
    hm.put(1'b1, 1'b1, 16'hc300);
    done <= 1'b1;
    @(posedge core_clk_in);
    done <= 1'b0;
    hm.put(1'b1, 1'b0, 16'h2100);
    rd(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk_in);
    if (cmd_q.size() != 0 || rd_q.size() != 0)
    begin
      fails++;
      $display("ERROR %0t results missing", $time);
    end
    close_out();
  end
endmodule
bind disk_command_status_unit disk_cmd_checker chk (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .cs_n_in(cs_n_in), .re_n_in(re_n_in), .addr_in(addr_in),
  .byte_mode_in(byte_mode_in), .command_done_in(command_done_in),
  .buffer_select_out_in(buffer_select_out_in),
  .buffer_transfer_request_in(buffer_transfer_request_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .command_start_out(command_start_out),
  .command_active_out(command_active_out), .op_out(op_out), .crc_verify_out(crc_verify_out),
  .sector_mode_out(sector_mode_out), .vol_head_out(vol_head_out), .cyl_out(cyl_out),
  .head_out(head_out), .marginal_out(marginal_out), .unit_flags_out(unit_flags_out));
